// ### src/clr_pkg.sv
// Package of offsets, field layouts and default codes for the limit registers.
package clr_pkg;
  // Register offsets.
  localparam logic [7:0] OFS_BATV = 8'h01;
  localparam logic [7:0] OFS_CHGI = 8'h03;
  localparam logic [7:0] OFS_INVF = 8'h05;
  localparam logic [7:0] OFS_INCL = 8'h06;
  localparam logic [7:0] OFS_TERM = 8'h09;
  // Field widths and positions.
  localparam int BATV_W   = 11;
  localparam int CHGI_W   = 9;
  localparam int INVF_W   = 8;
  localparam int INCL_W   = 9;
  localparam int REGRST_B = 6;
  // Lowest legal codes; smaller writes are clamped up to these.
  localparam logic [10:0] BATV_MIN = 11'h12c; // 3000 mV at 10 mV.
  localparam logic [8:0]  CHGI_MIN = 9'h005;  // 50 mA at 10 mA.
  localparam logic [7:0]  INVF_MIN = 8'h24;   // 3600 mV at 100 mV.
  localparam logic [8:0]  INCL_MIN = 9'h00a;  // 100 mA at 10 mA.
  // Power-on defaults; battery voltage and charge current by cell count.
  localparam logic [10:0] BATV_1S = 11'h1a4;  // 4.2 V.
  localparam logic [10:0] BATV_2S = 11'h348;  // 8.4 V.
  localparam logic [10:0] BATV_3S = 11'h4ec;  // 12.6 V.
  localparam logic [10:0] BATV_4S = 11'h690;  // 16.8 V.
  localparam logic [8:0]  CHGI_LO = 9'h0c8;   // 2 A for one or two cells.
  localparam logic [8:0]  CHGI_HI = 9'h064;   // 1 A for three or four cells.
  localparam logic [7:0]  INVF_RST = 8'h24;   // 3600 mV.
  localparam logic [8:0]  INCL_RST = 9'h12c;  // 3000 mA.
  // Input current ceilings by adapter class.
  localparam logic [8:0]  INCL_SDP  = 9'h032; // 500 mA.
  localparam logic [8:0]  INCL_CDP  = 9'h096; // 1.5 A.
  localparam logic [8:0]  INCL_DCP  = 9'h145; // 3.25 A.
  localparam logic [8:0]  INCL_HV   = 9'h096; // 1.5 A.
  localparam logic [8:0]  INCL_UNK  = 9'h12c; // 3 A.
  localparam logic [8:0]  INCL_NS1  = 9'h064; // 1 A.
  localparam logic [8:0]  INCL_NS2  = 9'h0c8; // 2 A.
  localparam logic [8:0]  INCL_NS21 = 9'h0d2; // 2.1 A.
  localparam logic [8:0]  INCL_NS24 = 9'h0f0; // 2.4 A.
  // Adapter classes reported by data-line detection.
  localparam logic [2:0] ADP_SDP = 3'h0;
  localparam logic [2:0] ADP_CDP = 3'h1;
  localparam logic [2:0] ADP_DCP = 3'h2;
  localparam logic [2:0] ADP_HV  = 3'h3;
  localparam logic [2:0] ADP_UNK = 3'h4;
  localparam logic [2:0] ADP_NS  = 3'h5;
  // Cycles after reset release at which the sensed cell count is taken.
  localparam logic [1:0] INIT_LOAD = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;
endpackage

// ### src/clr_limit_regs.sv
// Charger limit register bank: four regulation limits with defaults.
// Contract
// - Battery voltage limit: 11-bit 10 mV code, 3000-18800 mV, clamped low.
// - Power-on cell count loads 4.2, 8.4, 12.6 or 16.8 V as battery default.
// - Battery limit is read/write; only the power-on load and the defaults command restore it.
// - Charge current limit: 9-bit 10 mA code, 50-5000 mA, clamped low.
// - Charge current default is 2 A for 1-2 cells and 1 A for 3-4 cells.
// - Watchdog expiry and the defaults command restore the charge current.
// - Input floor: 8-bit 100 mV code, 3600-22000 mV, clamped low, reset 24h.
// - On adapter removal the input voltage floor reloads the 3600 mV code.
// - On adapter attach the floor takes the code from the bus measurement.
// - The floor keeps its value through defaults command and watchdog.
// - Input ceiling: 9-bit 10 mA code, 100-3300 mA, clamped low, reset 12Ch.
// - After data-line detection the ceiling follows the adapter class.
// - Bit 6 set in termination control resets defaults and the timer.
`timescale 1ns/1ps
module clr_limit_regs (
  // Clock and reset.
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // Register port from the serial management front end.
  input  wire logic                        wr_en,
  input  wire logic [7:0]                  wr_addr,
  input  wire logic [15:0]                 wr_data,
  input  wire logic                        rd_en,
  input  wire logic [7:0]                  rd_addr,
  output logic      [15:0]                 rd_data,
  // Cell count sensed from the configuration pin resistor.
  input  wire logic [1:0]                  cell_config_pin,
  // Watchdog expiry and adapter events from charger logic.
  input  wire logic                        wdog_expired,
  input  wire logic                        adapter_present,
  input  wire logic [7:0]                  vbus_floor_code,
  input  wire logic                        detect_done,
  input  wire logic [2:0]                  adapter_class,
  input  wire logic [1:0]                  nonstd_sel,
  // Limits to the regulation loops and timer restart.
  output logic [clr_pkg::BATV_W-1:0]       battery_voltage_limit,
  output logic [clr_pkg::CHGI_W-1:0]       charge_current_setting,
  output logic [clr_pkg::INVF_W-1:0]       input_voltage_floor,
  output logic [clr_pkg::INCL_W-1:0]       input_current_ceiling,
  output logic                             timer_restart
);
  import clr_pkg::*;

  logic [1:0]        cell_s1_q;
  logic [1:0]        cell_s2_q;
  logic [1:0]        cell_q;
  logic [1:0]        init_cnt_q;
  logic              adp_q;
  logic [BATV_W-1:0] batv_q;
  logic [BATV_W-1:0] batv_d;
  logic [CHGI_W-1:0] chgi_q;
  logic [CHGI_W-1:0] chgi_d;
  logic [INVF_W-1:0] invf_q;
  logic [INVF_W-1:0] invf_d;
  logic [INCL_W-1:0] incl_q;
  logic [INCL_W-1:0] incl_d;
  logic [15:0]       rd_q;
  logic [15:0]       rd_d;
  logic              trst_q;

  // Decodes of host writes and hardware events.
  wire init_w   = (init_cnt_q == INIT_LOAD);
  wire wr_batv  = wr_en && (wr_addr == OFS_BATV);
  wire wr_chgi  = wr_en && (wr_addr == OFS_CHGI);
  wire wr_invf  = wr_en && (wr_addr == OFS_INVF);
  wire wr_incl  = wr_en && (wr_addr == OFS_INCL);
  wire regrst_w = wr_en && (wr_addr == OFS_TERM) && wr_data[REGRST_B];
  wire attach_w = adapter_present && !adp_q;
  wire remove_w = !adapter_present && adp_q;

  // Written values with low clamping applied.
  wire [BATV_W-1:0] batv_wr = (wr_data[BATV_W-1:0] < BATV_MIN) ?
                              BATV_MIN : wr_data[BATV_W-1:0];
  wire [CHGI_W-1:0] chgi_wr = (wr_data[CHGI_W-1:0] < CHGI_MIN) ?
                              CHGI_MIN : wr_data[CHGI_W-1:0];
  wire [INVF_W-1:0] invf_wr = (wr_data[INVF_W-1:0] < INVF_MIN) ?
                              INVF_MIN : wr_data[INVF_W-1:0];
  wire [INCL_W-1:0] incl_wr = (wr_data[INCL_W-1:0] < INCL_MIN) ?
                              INCL_MIN : wr_data[INCL_W-1:0];
  wire [INVF_W-1:0] invf_meas = (vbus_floor_code < INVF_MIN) ?
                                INVF_MIN : vbus_floor_code;

  // Cell-count defaults; init uses the freshly synchronised pin value.
  wire [1:0] cell_sel = init_w ? cell_s2_q : cell_q;
  wire [BATV_W-1:0] batv_def = (cell_sel == 2'h0) ? BATV_1S :
                               (cell_sel == 2'h1) ? BATV_2S :
                               (cell_sel == 2'h2) ? BATV_3S :
                               BATV_4S;
  wire [CHGI_W-1:0] chgi_def = cell_sel[1] ? CHGI_HI : CHGI_LO;

  // Input current ceiling for the detected adapter class.
  wire [INCL_W-1:0] ns_code  = (nonstd_sel == 2'h0) ? INCL_NS1 :
                               (nonstd_sel == 2'h1) ? INCL_NS2 :
                               (nonstd_sel == 2'h2) ? INCL_NS21 :
                               INCL_NS24;
  wire [INCL_W-1:0] det_code = (adapter_class == ADP_SDP) ? INCL_SDP :
                               (adapter_class == ADP_CDP) ? INCL_CDP :
                               (adapter_class == ADP_DCP) ? INCL_DCP :
                               (adapter_class == ADP_HV)  ? INCL_HV :
                               (adapter_class == ADP_NS)  ? ns_code :
                               INCL_UNK;

  // Battery voltage: only init and the defaults command restore it.
  always_comb begin
    batv_d = batv_q;
    if (init_w || regrst_w) begin
      batv_d = batv_def;
    end else if (wr_batv) begin
      batv_d = batv_wr;
    end
  end

  // Charge current: watchdog and defaults command both restore it.
  always_comb begin
    chgi_d = chgi_q;
    if (init_w || regrst_w || wdog_expired) begin
      chgi_d = chgi_def;
    end else if (wr_chgi) begin
      chgi_d = chgi_wr;
    end
  end

  // Input voltage floor: adapter events, then host; never the reset sources.
  always_comb begin
    invf_d = invf_q;
    if (remove_w) begin
      invf_d = INVF_RST;
    end else if (attach_w) begin
      invf_d = invf_meas;
    end else if (wr_invf) begin
      invf_d = invf_wr;
    end
  end

  // Input current ceiling: defaults command, detection, then host.
  always_comb begin
    incl_d = incl_q;
    if (regrst_w) begin
      incl_d = INCL_RST;
    end else if (detect_done) begin
      incl_d = det_code;
    end else if (wr_incl) begin
      incl_d = incl_wr;
    end
  end

  // Read mux; reserved bits and unmapped offsets read as zero.
  always_comb begin
    rd_d = rd_q;
    if (rd_en) begin
      case (rd_addr)
        OFS_BATV: rd_d = {5'h00, batv_q};
        OFS_CHGI: rd_d = {7'h00, chgi_q};
        OFS_INVF: rd_d = {8'h00, invf_q};
        OFS_INCL: rd_d = {7'h00, incl_q};
        default:  rd_d = 16'h0000;
      endcase
    end
  end

  // Two-flop synchroniser for the configuration pin.
  always_ff @(posedge sys_clk) begin
    cell_s1_q <= cell_config_pin;
    cell_s2_q <= cell_s1_q;
  end

  // Post-reset sequencing and latch of the sensed cell count.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      init_cnt_q <= 2'h0;
      cell_q     <= 2'h0;
    end else begin
      if (init_cnt_q != INIT_DONE) begin
        init_cnt_q <= init_cnt_q + 2'h1;
      end
      if (init_w) begin
        cell_q <= cell_s2_q;
      end
    end
  end

  // Field registers, read data and timer restart pulse.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      adp_q  <= 1'b0;
      batv_q <= BATV_1S;
      chgi_q <= CHGI_LO;
      invf_q <= INVF_RST;
      incl_q <= INCL_RST;
      rd_q   <= 16'h0000;
      trst_q <= 1'b0;
    end else begin
      adp_q  <= adapter_present;
      batv_q <= batv_d;
      chgi_q <= chgi_d;
      invf_q <= invf_d;
      incl_q <= incl_d;
      rd_q   <= rd_d;
      trst_q <= regrst_w;
    end
  end

  assign rd_data                = rd_q;
  assign battery_voltage_limit  = batv_q;
  assign charge_current_setting = chgi_q;
  assign input_voltage_floor    = invf_q;
  assign input_current_ceiling  = incl_q;
  assign timer_restart          = trst_q;

  // A low battery voltage write settles at the minimum code.
  property p_batv_clamp;
    @(posedge sys_clk) disable iff (sys_rst)
    (wr_batv && !regrst_w && !init_w && wr_data[10:0] < BATV_MIN)
      |=> (battery_voltage_limit == BATV_MIN);
  endproperty
  a_batv_clamp: assert property (p_batv_clamp)
    else $error("battery voltage limit not clamped");

  // Power-on load follows the synchronised cell count.
  property p_init_load;
    @(posedge sys_clk) disable iff (sys_rst)
    init_w |=> (battery_voltage_limit == ((cell_q == 2'h0) ? BATV_1S :
               (cell_q == 2'h1) ? BATV_2S : (cell_q == 2'h2) ? BATV_3S :
               BATV_4S)) && (charge_current_setting ==
               (cell_q[1] ? CHGI_HI : CHGI_LO));
  endproperty
  a_init_load: assert property (p_init_load)
    else $error("power-on defaults wrong");

  // Watchdog leaves the battery voltage limit untouched.
  property p_batv_wdog;
    @(posedge sys_clk) disable iff (sys_rst)
    (wdog_expired && !wr_batv && !regrst_w && !init_w)
      |=> $stable(battery_voltage_limit);
  endproperty
  a_batv_wdog: assert property (p_batv_wdog)
    else $error("battery voltage limit changed on watchdog");

  // A low charge current write settles at the minimum code.
  property p_chgi_clamp;
    @(posedge sys_clk) disable iff (sys_rst)
    (wr_chgi && !regrst_w && !wdog_expired && !init_w &&
     wr_data[8:0] < CHGI_MIN) |=> (charge_current_setting == CHGI_MIN);
  endproperty
  a_chgi_clamp: assert property (p_chgi_clamp)
    else $error("charge current not clamped");

  // Watchdog restores the charge current default.
  property p_chgi_wdog;
    @(posedge sys_clk) disable iff (sys_rst)
    (wdog_expired && init_cnt_q == INIT_DONE)
      |=> (charge_current_setting == (cell_q[1] ? CHGI_HI : CHGI_LO));
  endproperty
  a_chgi_wdog: assert property (p_chgi_wdog)
    else $error("charge current not restored by watchdog");

  // Adapter removal reloads the floor on the edge after the input falls.
  property p_invf_remove;
    @(posedge sys_clk) disable iff (sys_rst)
    $fell(adapter_present) |=> (input_voltage_floor == INVF_RST);
  endproperty
  a_invf_remove: assert property (p_invf_remove)
    else $error("input voltage floor not reloaded on removal");

  // Adapter attach takes the clamped measurement.
  property p_invf_attach;
    @(posedge sys_clk) disable iff (sys_rst)
    attach_w |=> (input_voltage_floor == $past(invf_meas));
  endproperty
  a_invf_attach: assert property (p_invf_attach)
    else $error("input voltage floor not set on attach");

  // Reset sources never disturb the floor.
  property p_invf_keep;
    @(posedge sys_clk) disable iff (sys_rst)
    ((regrst_w || wdog_expired) && !attach_w && !remove_w && !wr_invf)
      |=> $stable(input_voltage_floor);
  endproperty
  a_invf_keep: assert property (p_invf_keep)
    else $error("input voltage floor disturbed by reset source");

  // A low input current write settles at the minimum code.
  property p_incl_clamp;
    @(posedge sys_clk) disable iff (sys_rst)
    (wr_incl && !regrst_w && !detect_done && wr_data[8:0] < INCL_MIN)
      |=> (input_current_ceiling == INCL_MIN);
  endproperty
  a_incl_clamp: assert property (p_incl_clamp)
    else $error("input current not clamped");

  // A detected dedicated charger yields 3.25 A.
  property p_incl_dcp;
    @(posedge sys_clk) disable iff (sys_rst)
    (detect_done && !regrst_w && adapter_class == ADP_DCP)
      |=> (input_current_ceiling == INCL_DCP);
  endproperty
  a_incl_dcp: assert property (p_incl_dcp)
    else $error("input current wrong after detection");

  // Defaults command restores the input current ceiling and pulses the timer restart once.
  property p_regrst;
    @(posedge sys_clk) disable iff (sys_rst)
    (regrst_w && !detect_done) |=>
      (timer_restart && (input_current_ceiling == INCL_RST)) ##1
      (!timer_restart || $past(regrst_w));
  endproperty
  a_regrst: assert property (p_regrst)
    else $error("register defaults command not honoured");

  // Main scenarios.
  c_regrst: cover property (@(posedge sys_clk) disable iff (sys_rst)
    regrst_w);
  c_attach_remove: cover property (@(posedge sys_clk) disable iff (sys_rst)
    attach_w ##[1:50] remove_w);
  c_detect_ns: cover property (@(posedge sys_clk) disable iff (sys_rst)
    detect_done && adapter_class == ADP_NS);
endmodule

// ### dv/clr_host_model.sv
// Host model that issues register writes and reads on the bank port.
`timescale 1ns/1ps
module clr_host_model (
  // Clock.
  input  wire logic        sys_clk,
  // Register port towards the bank.
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [15:0]      wr_data,
  output logic             rd_en,
  output logic [7:0]       rd_addr,
  input  wire logic [15:0] rd_data
);
  // Idle port at time zero.
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end

  // One write strobe; the released lines then show the inverse.
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge sys_clk);
    #1;
    wr_en   = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask

  // One read strobe; data is taken once the sampling edge has passed.
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #1;
    rd_en   = 1'b1;
    rd_addr = a;
    @(posedge sys_clk);
    #1;
    rd_en   = 1'b0;
    rd_addr = ~a;
    d       = rd_data;
  endtask
endmodule

// ### dv/test_clr_limit_regs.sv
// Self-checking bench for the charger limit register bank.
`timescale 1ns/1ps
module test_clr_limit_regs;
  import clr_pkg::*;
  // Clock, reset and register port.
  logic              sys_clk;
  logic              sys_rst;
  logic              wr_en;
  logic [7:0]        wr_addr;
  logic [15:0]       wr_data;
  logic              rd_en;
  logic [7:0]        rd_addr;
  logic [15:0]       rd_data;
  // Charger side inputs and limit outputs.
  logic [1:0]        cell_config_pin;
  logic              wdog_expired;
  logic              adapter_present;
  logic [7:0]        vbus_floor_code;
  logic              detect_done;
  logic [2:0]        adapter_class;
  logic [1:0]        nonstd_sel;
  logic [BATV_W-1:0] battery_voltage_limit;
  logic [CHGI_W-1:0] charge_current_setting;
  logic [INVF_W-1:0] input_voltage_floor;
  logic [INCL_W-1:0] input_current_ceiling;
  logic              timer_restart;
  int                err_total;
  int                n_compared;
  int                cycles;
  logic [10:0]       batv_tab [4] = '{BATV_1S, BATV_2S, BATV_3S, BATV_4S};

  clr_host_model host (.sys_clk, .wr_en, .wr_addr, .wr_data, .rd_en,
                       .rd_addr, .rd_data);
  clr_limit_regs dut (.sys_clk, .sys_rst, .wr_en, .wr_addr, .wr_data,
    .rd_en, .rd_addr, .rd_data, .cell_config_pin, .wdog_expired,
    .adapter_present, .vbus_floor_code, .detect_done, .adapter_class,
    .nonstd_sel, .battery_voltage_limit, .charge_current_setting,
    .input_voltage_floor, .input_current_ceiling, .timer_restart);

  // Clock of 40 ns period.
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // Hang guard: far above the length of all scenarios.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input string n, input logic [15:0] s, e);
    n_compared = n_compared + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Steps to just after the next rising edge.
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // Reads a register over the bus and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    host.read_reg(a, v);
    check("readback", v, e);
  endtask

  // Limit output that belongs to a register offset.
  function automatic logic [15:0] out_of(input logic [7:0] a);
    case (a)
      OFS_BATV: return 16'(battery_voltage_limit);
      OFS_CHGI: return 16'(charge_current_setting);
      OFS_INVF: return 16'(input_voltage_floor);
      default:  return 16'(input_current_ceiling);
    endcase
  endfunction

  // Reset with a given cell count, then wait past the default load.
  task automatic do_reset(input logic [1:0] c);
    cell_config_pin = c;
    sys_rst = 1'b1;
    repeat (5) tick();
    check("floor in reset", 16'(input_voltage_floor), 16'h0024);
    check("ceiling in reset", out_of(OFS_INCL), 16'h012c);
    sys_rst = 1'b0;
    repeat (5) tick();
  endtask

  // Every cell count loads its own battery and charge defaults.
  task automatic t_defaults();
    for (int c = 0; c < 4; c++) begin
      do_reset(2'(c));
      check("batv", out_of(OFS_BATV), 16'(batv_tab[c]));
      check("chgi", out_of(OFS_CHGI), c < 2 ? 16'h00c8 : 16'h0064);
      rd_chk(OFS_BATV, 16'(batv_tab[c]));
      rd_chk(OFS_INVF, 16'h0024);
      rd_chk(OFS_INCL, 16'h012c);
      // Leave non-default codes so that the next reset has work to do.
      host.write_reg(OFS_INVF, 16'h0060);
      host.write_reg(OFS_INCL, 16'h0011);
    end
  endtask

  // Boundary writes: below minimum clamps, top of range and high bits.
  task automatic t_write();
    logic [7:0]  a [10] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h05,
                            8'h05, 8'h06, 8'h06, 8'h06};
    logic [15:0] d [10] = '{16'h0000, 16'h012b, 16'hf758, 16'h0004,
                            16'h01f4, 16'h0023, 16'hffdc, 16'h0009,
                            16'h000a, 16'h014a};
    logic [15:0] e [10] = '{16'h012c, 16'h012c, 16'h0758, 16'h0005,
                            16'h01f4, 16'h0024, 16'h00dc, 16'h000a,
                            16'h000a, 16'h014a};
    for (int i = 0; i < 10; i++) begin
      host.write_reg(a[i], d[i]);
      check("field out", out_of(a[i]), e[i]);
      rd_chk(a[i], e[i]);
    end
    host.write_reg(8'h02, 16'h1234);
    rd_chk(8'h02, 16'h0000);
    rd_chk(OFS_TERM, 16'h0000);
  endtask

  // Watchdog restores only the charge current.
  task automatic t_wdog();
    wdog_expired = 1'b1;
    tick();
    wdog_expired = 1'b0;
    check("chgi wdog", out_of(OFS_CHGI), 16'h0064);
    check("batv wdog", out_of(OFS_BATV), 16'h0758);
    check("floor wdog", out_of(OFS_INVF), 16'h00dc);
    check("ceil wdog", out_of(OFS_INCL), 16'h014a);
  endtask

  // Defaults command, first with bit 6 clear, then set.
  task automatic t_regrst();
    host.write_reg(OFS_CHGI, 16'h01f4);
    host.write_reg(OFS_TERM, 16'hffbf);
    check("no restart", 16'(timer_restart), 16'h0000);
    check("batv kept", out_of(OFS_BATV), 16'h0758);
    host.write_reg(OFS_TERM, 16'h0040);
    check("restart", 16'(timer_restart), 16'h0001);
    check("batv dflt", out_of(OFS_BATV), 16'(BATV_4S));
    check("chgi dflt", out_of(OFS_CHGI), 16'h0064);
    check("ceil dflt", out_of(OFS_INCL), 16'h012c);
    check("floor kept", out_of(OFS_INVF), 16'h00dc);
    tick();
    check("restart end", 16'(timer_restart), 16'h0000);
  endtask

  // Attach, removal and a clamped attach code.
  task automatic t_adapter();
    vbus_floor_code = 8'h50;
    adapter_present = 1'b1;
    tick();
    check("floor attach", out_of(OFS_INVF), 16'h0050);
    vbus_floor_code = 8'h77;
    adapter_present = 1'b0;
    tick();
    check("floor remove", out_of(OFS_INVF), 16'h0024);
    host.write_reg(OFS_INVF, 16'h0060);
    vbus_floor_code = 8'h10;
    adapter_present = 1'b1;
    tick();
    check("floor clamp", out_of(OFS_INVF), 16'h0024);
  endtask

  // Every adapter class and non-standard level after a detection.
  task automatic t_detect();
    logic [8:0] ns [4] = '{9'h064, 9'h0c8, 9'h0d2, 9'h0f0};
    logic [8:0] cl [8] = '{9'h032, 9'h096, 9'h145, 9'h096, 9'h12c,
                           9'h000, 9'h12c, 9'h12c};
    logic [8:0] ex;
    for (int c = 0; c < 8; c++) begin
      for (int n = 0; n < 4; n++) begin
        host.write_reg(OFS_INCL, 16'h0011);
        adapter_class = 3'(c);
        nonstd_sel = 2'(n);
        detect_done = 1'b1;
        tick();
        detect_done = 1'b0;
        ex = (c == 5) ? ns[n] : cl[c];
        check("ceil class", out_of(OFS_INCL), 16'(ex));
      end
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    err_total = 0;
    n_compared = 0;
    cycles = 0;
    sys_rst = 1'b1;
    cell_config_pin = 2'h0;
    wdog_expired = 1'b0;
    adapter_present = 1'b0;
    vbus_floor_code = 8'h00;
    detect_done = 1'b0;
    adapter_class = 3'h0;
    nonstd_sel = 2'h0;
    t_defaults();
    t_write();
    t_wdog();
    t_regrst();
    t_adapter();
    t_detect();
    print_verdict();
  end
endmodule
